// ==== logic/cpm_period_decode.sv ====
`timescale 1ns/100ps
module cpm_period_decode (
    input  cpm_pkg::cpm_modctl_t        cfg_in,
    output logic [cpm_pkg::CPM_CNT_W-1:0] on_len_out,
    output logic [cpm_pkg::CPM_CNT_W-1:0] period_out,
    output logic                        counting_out,
    output logic                        hf_out
);
    import cpm_pkg::*;

    logic [CPM_CNT_W-1:0] unit;
    logic [1:0]           on_mult;
    logic [1:0]           off_mult;

    always_comb begin
        // RQ1 one unit
        unit     = CPM_CNT_W'({2'b00, cfg_in.on_time_field} + 7'h01);
        on_mult  = 2'h1;
        off_mult = 2'h1;
        counting_out = 1'b1;
        // RQ2 RQ3 duty table
        unique case (cfg_in.duty_select)
            CPM_DUTY_50: off_mult = 2'h1;
            CPM_DUTY_33: off_mult = 2'h2;
            CPM_DUTY_25: off_mult = 2'h3;
            CPM_DUTY_67: on_mult  = 2'h2;
            CPM_DUTY_75: on_mult  = 2'h3;
            CPM_DUTY_OFF, CPM_DUTY_RSVD, CPM_DUTY_HF: counting_out = 1'b0;
        endcase
        hf_out     = (cfg_in.duty_select == CPM_DUTY_HF);
        on_len_out = CPM_CNT_W'(unit * on_mult);
        // RQ4 RQ5 period up to 128 clocks
        period_out = CPM_CNT_W'(unit * (on_mult + off_mult) - 7'h01);
    end

endmodule

// ==== logic/cpm_pkg.sv ====
// Behaviour
// RQ1 - on-time field sits in bits 7..3; value plus one is one unit of clocks, pin low
// RQ2 - duty 000 unmodulated; 001/010/011 give one unit on, one/two/three units off
// RQ3 - duty 100/101 give two/three units on, one off; 110 reserved, never programmed
// RQ4 - field zero gives shortest period, 31 the longest; 2 to 128 clocks
// RQ5 - carrier frequency is clock over on-time plus off-time in clocks
// RQ6 - duty 111 gates the pin with the clock, period one clock
// RQ7 - software stops modulation by pin level high before leaving duty 111
// RQ8 - pin high when level bit 1; else low for duty 0, modulated for 1 to 7 (code also drives low for reserved 110)
// RQ9 - control written during modulation takes effect at next cycle start
// RQ10 - one timer tick per period, also while the level bit stops modulation
// RQ11 - modulation start, by level bit clear or timer action, drives low at next cycle start
// RQ12 - each cycle is on phase low, then off phase high, repeating
package cpm_pkg;

    localparam int CPM_ADDR_W = 8;
    localparam int CPM_DATA_W = 8;
    localparam int CPM_CNT_W  = 7;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [CPM_ADDR_W-1:0] CPM_MODCTL_OFS = 8'h02;
    localparam logic [CPM_ADDR_W-1:0] CPM_PINCTL_OFS = 8'h03;
    localparam logic [CPM_ADDR_W-1:0] CPM_STATUS_OFS = 8'h04;

    localparam logic [CPM_DATA_W-1:0] CPM_MODCTL_RST = 8'h00;
    localparam logic                  CPM_PINLVL_RST = 1'b0;

    localparam int CPM_ONTIME_MSB = 7;
    localparam int CPM_ONTIME_LSB = 3;
    localparam int CPM_DUTY_MSB   = 2;
    localparam int CPM_DUTY_LSB   = 0;

    localparam int CPM_ST_LEVEL  = 0;
    localparam int CPM_ST_RUN    = 1;
    localparam int CPM_ST_HF     = 2;
    localparam int CPM_ST_PEND   = 3;

    localparam logic [CPM_CNT_W-1:0] CPM_CNT_RST = 7'h00;

    typedef enum logic [2:0] {
        CPM_DUTY_OFF  = 3'h0,
        CPM_DUTY_50   = 3'h1,
        CPM_DUTY_33   = 3'h2,
        CPM_DUTY_25   = 3'h3,
        CPM_DUTY_67   = 3'h4,
        CPM_DUTY_75   = 3'h5,
        CPM_DUTY_RSVD = 3'h6,
        CPM_DUTY_HF   = 3'h7
    } cpm_duty_t;

    typedef struct packed {
        logic [4:0] on_time_field;
        cpm_duty_t  duty_select;
    } cpm_modctl_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [CPM_ADDR_W-1:0] addr;
        logic [CPM_DATA_W-1:0] wdata;
    } cpm_bus_req_t;

endpackage

// ==== logic/cpm_top.sv ====
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module cpm_top (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rstn_in,
    input  wire cpm_pkg::cpm_bus_req_t         bus_in,
    output logic [cpm_pkg::CPM_DATA_W-1:0]     rdata_out,
    input  wire logic                          ovf_clear_in,
    input  wire logic                          ovf_set_in,
    output logic                               led_level_out,
    output logic                               led_clk_gate_out,
    output logic                               timer_tick_out
);
    import cpm_pkg::*;

    // ************************************************************
    // register state
    // ************************************************************
    cpm_modctl_t           modulation_control;
    cpm_modctl_t           next_modulation_control;
    logic                  pin_drive_level_bit;
    logic                  next_pin_drive_level_bit;
    logic [CPM_DATA_W-1:0] next_rdata;

    // ************************************************************
    // modulator state
    // ************************************************************
    cpm_modctl_t           active_cfg;
    cpm_modctl_t           next_active_cfg;
    logic [CPM_CNT_W-1:0]  cnt;
    logic [CPM_CNT_W-1:0]  next_cnt;
    logic                  run;
    logic                  next_run;
    logic                  next_led_level;
    logic                  next_led_clk_gate;
    logic                  next_timer_tick;

    logic [CPM_CNT_W-1:0]  cur_on_len;
    logic [CPM_CNT_W-1:0]  cur_period;
    logic                  cur_counting;
    logic                  cur_hf;
    logic [CPM_CNT_W-1:0]  nxt_on_len;
    logic [CPM_CNT_W-1:0]  nxt_period;
    logic                  nxt_counting;
    logic                  nxt_hf;
    logic                  last;

    cpm_period_decode u_dec_cur (
        .cfg_in       (active_cfg),
        .on_len_out   (cur_on_len),
        .period_out   (cur_period),
        .counting_out (cur_counting),
        .hf_out       (cur_hf)
    );

    cpm_period_decode u_dec_nxt (
        .cfg_in       (next_active_cfg),
        .on_len_out   (nxt_on_len),
        .period_out   (nxt_period),
        .counting_out (nxt_counting),
        .hf_out       (nxt_hf)
    );

    // ************************************************************
    // register access
    // ************************************************************
    always_comb begin
        next_modulation_control  = modulation_control;
        next_pin_drive_level_bit = pin_drive_level_bit;
        next_rdata               = '0;
        if (bus_in.wr) begin
            if (bus_in.addr == CPM_MODCTL_OFS) begin
                // RQ1 field layout
                next_modulation_control.on_time_field =
                    bus_in.wdata[CPM_ONTIME_MSB:CPM_ONTIME_LSB];
                next_modulation_control.duty_select =
                    cpm_duty_t'(bus_in.wdata[CPM_DUTY_MSB:CPM_DUTY_LSB]);
            end
            if (bus_in.addr == CPM_PINCTL_OFS) begin
                next_pin_drive_level_bit = bus_in.wdata[0];
            end
        end
        // RQ11 timer action; set wins, it stops the burst
        if (ovf_clear_in) begin
            next_pin_drive_level_bit = 1'b0;
        end
        if (ovf_set_in) begin
            next_pin_drive_level_bit = 1'b1;
        end
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                CPM_MODCTL_OFS: next_rdata = modulation_control;
                CPM_PINCTL_OFS: next_rdata = {7'h00, pin_drive_level_bit};
                CPM_STATUS_OFS: begin
                    next_rdata[CPM_ST_LEVEL] = led_level_out;
                    next_rdata[CPM_ST_RUN]   = run;
                    next_rdata[CPM_ST_HF]    = led_clk_gate_out;
                    next_rdata[CPM_ST_PEND]  = (active_cfg != modulation_control);
                end
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            modulation_control  <= cpm_modctl_t'(CPM_MODCTL_RST);
            pin_drive_level_bit <= CPM_PINLVL_RST;
            rdata_out           <= '0;
        end else begin
            modulation_control  <= next_modulation_control;
            pin_drive_level_bit <= next_pin_drive_level_bit;
            rdata_out           <= next_rdata;
        end
    end

    // ************************************************************
    // period sequencing
    // ************************************************************
    always_comb begin
        last = cur_counting && (cnt == cur_period);
        // RQ9 adopt new setting at a cycle boundary, or at once while the active duty is not counting
        if (last || !cur_counting) begin
            next_active_cfg = modulation_control;
        end else begin
            next_active_cfg = active_cfg;
        end

        // RQ12 counter restarts each period, on phase first
        if (last || !nxt_counting) begin
            next_cnt = CPM_CNT_RST;
        end else if (!cur_counting) begin
            next_cnt = CPM_CNT_RST;
        end else begin
            next_cnt = CPM_CNT_W'(cnt + 7'h01);
        end

        // RQ11 start waits for the next cycle boundary
        if (pin_drive_level_bit || !nxt_counting) begin
            next_run = 1'b0;
        end else if (last || !cur_counting) begin
            next_run = 1'b1;
        end else begin
            next_run = run;
        end

        // RQ8 level bit, duty zero, modulated
        if (pin_drive_level_bit) begin
            next_led_level = 1'b1;
        end else if (next_active_cfg.duty_select == CPM_DUTY_OFF ||
                     next_active_cfg.duty_select == CPM_DUTY_RSVD) begin
            next_led_level = 1'b0;
        end else if (nxt_hf) begin
            next_led_level = 1'b1;
        end else if (next_run) begin
            // RQ12 low in on phase, high in off phase
            next_led_level = (next_cnt < nxt_on_len) ? 1'b0 : 1'b1;
        end else begin
            next_led_level = 1'b1;
        end

        // RQ6 pad gates level with the clock; RQ7 left to software
        next_led_clk_gate = !pin_drive_level_bit && nxt_hf;

        // RQ10 tick per period regardless of level bit
        next_timer_tick = last || cur_hf;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            active_cfg       <= cpm_modctl_t'(CPM_MODCTL_RST);
            cnt              <= CPM_CNT_RST;
            run              <= 1'b0;
            led_level_out    <= CPM_PINLVL_RST;
            led_clk_gate_out <= 1'b0;
            timer_tick_out   <= 1'b0;
        end else begin
            active_cfg       <= next_active_cfg;
            cnt              <= next_cnt;
            run              <= next_run;
            led_level_out    <= next_led_level;
            led_clk_gate_out <= next_led_clk_gate;
            timer_tick_out   <= next_timer_tick;
        end
    end

endmodule

// ==== verif/cpm_checker_props.sv ====
`timescale 1ns/100ps
module cpm_checker (
    input wire logic                         clk_sys_in,
    input wire logic                         rstn_in,
    input wire cpm_pkg::cpm_bus_req_t        bus_in,
    input wire logic [cpm_pkg::CPM_DATA_W-1:0] rdata_out,
    input wire logic                         ovf_clear_in,
    input wire logic                         ovf_set_in,
    input wire logic                         led_level_out,
    input wire logic                         led_clk_gate_out,
    input wire logic                         timer_tick_out
);
    import cpm_pkg::*;
    logic [7:0] ctl, next_ctl;
    logic [1:0] age, next_age;
    // age: cycles since last clock-gated setting, so late ticks are excused
    always_comb begin
        next_ctl = (bus_in.wr && bus_in.addr == CPM_MODCTL_OFS) ? bus_in.wdata : ctl;
        next_age = (ctl[2:0] == 3'h7 || led_clk_gate_out) ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    end
    always_ff @(posedge clk_sys_in) begin
        ctl <= rstn_in ? next_ctl : CPM_MODCTL_RST;
        age <= rstn_in ? next_age : 2'h0;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_ctl_read: assert property (bus_in.rd && bus_in.addr == CPM_MODCTL_OFS |=> rdata_out == ctl)
        else $error("control read mismatch");
    a_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data not idle");
    a_bad_addr: assert property (bus_in.rd && bus_in.addr > 8'h04 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_level_set: assert property (bus_in.wr && bus_in.addr == CPM_PINCTL_OFS && bus_in.wdata[0]
        && !ovf_clear_in && !ovf_set_in |-> ##2 led_level_out) else $error("pin level not high");
    a_ovf_set: assert property (ovf_set_in |-> ##2 led_level_out)
        else $error("overflow set ignored");
    a_gate_high: assert property (led_clk_gate_out |-> led_level_out)
        else $error("gate with level low");
    a_hf_tick: assert property (led_clk_gate_out && $past(led_clk_gate_out) |-> timer_tick_out)
        else $error("tick missing in gated mode");
    a_tick_gap: assert property (timer_tick_out && age == 2'h3 |=> !timer_tick_out)
        else $error("ticks closer than two cycles");
    cover property (timer_tick_out && !led_clk_gate_out);
    cover property (led_clk_gate_out);
    cover property (ovf_set_in && ovf_clear_in);
endmodule
bind cpm_top cpm_checker u_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .ovf_clear_in(ovf_clear_in), .ovf_set_in(ovf_set_in),
    .led_level_out(led_level_out), .led_clk_gate_out(led_clk_gate_out), .timer_tick_out(timer_tick_out));

// ==== verif/cpm_led_model.sv ====
`timescale 1ns/100ps
module cpm_led_model (
    input  wire logic clk_in,
    input  wire logic level_in,
    input  wire logic gate_in,
    output logic      lit_out
);
    // led conducts while the pad sinks current (pin low)
    assign lit_out = !(gate_in ? clk_in : level_in);
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import cpm_pkg::*;
    logic         clk_sys_in = 1'b0;
    logic         rstn_in = 1'b0;
    cpm_bus_req_t bus = '0;
    logic         oclr = 1'b0;
    logic         oset = 1'b0;
    logic [7:0]   rdata;
    logic         level, gate, tick, lit;
    int           bad_count = 0;
    int           compares = 0;
    int           onm[6] = '{0, 1, 1, 1, 2, 3};
    int           offm[6] = '{0, 1, 2, 3, 1, 1};
    int           lo, tk;
    always #5 clk_sys_in = ~clk_sys_in;
    cpm_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
        .ovf_clear_in(oclr), .ovf_set_in(oset), .led_level_out(level),
        .led_clk_gate_out(gate), .timer_tick_out(tick));
    cpm_led_model led (.clk_in(clk_sys_in), .level_in(level), .gate_in(gate), .lit_out(lit));
    // ********
    // bus and compare tasks
    // ********
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_in);
        bus <= '0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_in);
        bus <= '0;
        #1 check(what, rdata, exp);
        @(posedge clk_sys_in);
    endtask
    task automatic wait_for(bit tk, logic v);
        for (int i = 0; i < 300 && (tk ? tick : level) !== v; i++) @(negedge clk_sys_in);
    endtask
    task automatic period(int d, int t);
        int hi, gap;
        // two period starts pass so the new setting is surely adopted
        repeat (2) begin
            wait_for(0, 1'b1);
            wait_for(0, 1'b0);
        end
        for (lo = 0; level === 1'b0 && lo < 300; lo++) @(negedge clk_sys_in);
        for (hi = 0; level === 1'b1 && hi < 300; hi++) @(negedge clk_sys_in);
        wait_for(1, 1'b1);
        @(negedge clk_sys_in);
        for (gap = 1; tick !== 1'b1 && gap < 300; gap++) @(negedge clk_sys_in);
        check("on time", 8'(lo), 8'(onm[d] * (t + 1)));
        check("off time", 8'(hi), 8'(offm[d] * (t + 1)));
        check("tick gap", 8'(gap), 8'((onm[d] + offm[d]) * (t + 1)));
        @(posedge clk_sys_in);
    endtask
    task automatic tally(int n);
        lo = 0;
        tk = 0;
        repeat (n) begin
            @(negedge clk_sys_in);
            lo += int'(level === 1'b0);
            tk += int'(tick === 1'b1);
        end
        @(posedge clk_sys_in);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(CPM_MODCTL_OFS, CPM_MODCTL_RST, "control reset");
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00, "unmapped");
        wr(CPM_MODCTL_OFS, 8'hFB);
        rd(CPM_MODCTL_OFS, 8'hFB, "control");
        $display("test registers done");
        for (int d = 1; d < 6; d++) begin
            for (int k = 0; k < 3; k++) begin
                wr(CPM_MODCTL_OFS, {5'(k == 0 ? 0 : k == 1 ? 31 : 5 * d), 3'(d)});
                period(d, k == 0 ? 0 : k == 1 ? 31 : 5 * d);
            end
        end
        $display("test duty sweep done");
        wr(CPM_PINCTL_OFS, 8'h01);
        wr(CPM_MODCTL_OFS, 8'h19);
        repeat (140) @(posedge clk_sys_in);
        tally(64);
        check("low while stopped", 8'(lo), 8'h00);
        check("ticks while stopped", 8'(tk), 8'h08);
        rd(CPM_PINCTL_OFS, 8'h01, "level bit");
        rd(CPM_STATUS_OFS, 8'h01, "status stopped");
        $display("test stopped ticks done");
        wr(CPM_MODCTL_OFS, 8'h07);
        wr(CPM_PINCTL_OFS, 8'h00);
        // the new duty waits for the end of the running period
        repeat (12) @(posedge clk_sys_in);
        tally(16);
        check("gated ticks", 8'(tk), 8'h10);
        rd(CPM_STATUS_OFS, 8'h05, "status gated");
        @(negedge clk_sys_in);
        // let the pad model settle after the clock edge
        #1 check("gated pad", {6'h00, gate, lit}, 8'h03);
        wr(CPM_PINCTL_OFS, 8'h01);
        wr(CPM_MODCTL_OFS, 8'h01);
        repeat (4) @(negedge clk_sys_in);
        check("stopped pad", {7'h00, lit}, 8'h00);
        $display("test gated mode done");
        wr(CPM_MODCTL_OFS, 8'h00);
        @(posedge clk_sys_in);
        oclr <= 1'b1;
        @(posedge clk_sys_in);
        oclr <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        tally(20);
        check("unmodulated low", 8'(lo), 8'd20);
        check("unmodulated ticks", 8'(tk), 8'h00);
        oclr <= 1'b1;
        oset <= 1'b1;
        @(posedge clk_sys_in);
        oclr <= 1'b0;
        oset <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        tally(10);
        check("overflow set", 8'(lo), 8'h00);
        // start by timer clear action, then measure full periods
        wr(CPM_MODCTL_OFS, 8'h19);
        oclr <= 1'b1;
        @(posedge clk_sys_in);
        oclr <= 1'b0;
        period(1, 3);
        $display("test overflow actions done");
        summarize();
    end
endmodule
